// >>> hw/sirp_i2c_port.sv
/*
 * two-wire target port with the seventeen-register map of the sensor.
 * the bus engine runs on the link clock and oversamples the bus pins;
 * the register file and command logic run on the system clock.
 * assumes a link clock at least 4x faster than the bus clock and a
 * measurement engine that pulses done on the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sirp_defs.svh"

module sirp_i2c_port #(
    parameter int NREG = `SIRP_REG_COUNT
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_clk_link,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    output logic o_int_out,
    output logic o_int_oe,
    input wire logic i_ambient_done,
    input wire logic i_bio_done,
    input wire logic [15:0] i_ambient_result,
    input wire logic [15:0] i_bio_result,
    output logic o_ambient_start,
    output logic o_bio_start,
    output logic o_ambient_periodic,
    output logic o_bio_periodic,
    output logic o_self_timed
);
    // register index of a bus address, valid only inside the map
    function automatic logic [4:0] reg_idx(input logic [7:0] a);
        logic [7:0] d;
        d = a - `SIRP_REG_BASE;
        return d[4:0];
    endfunction

    function automatic logic in_map(input logic [7:0] a);
        return (a >= `SIRP_REG_BASE) && (a <= `SIRP_REG_LAST);
    endfunction

    logic rst_link;
    logic [1:0] pin_s;
    logic req_go;
    logic req_evt;
    logic ack_go;
    logic ack_evt;

    // link-side reset and bus pins, both through two flops
    sirp_sync #(.W(1)) u_rst_sync (
        .i_clk(i_clk_link),
        .i_d(i_rst),
        .o_q(rst_link)
    );

    sirp_sync #(.W(2)) u_pin_sync (
        .i_clk(i_clk_link),
        .i_d({i_scl, i_sda}),
        .o_q(pin_s)
    );

    // access request towards the system side, answer back
    sirp_pulse_xfer u_req_xfer (
        .i_clk_src(i_clk_link),
        .i_rst_src(rst_link),
        .i_pulse(req_go),
        .i_clk_dst(i_clk_sys),
        .i_rst_dst(i_rst),
        .o_pulse(req_evt)
    );

    sirp_pulse_xfer u_ack_xfer (
        .i_clk_src(i_clk_sys),
        .i_rst_src(i_rst),
        .i_pulse(ack_go),
        .i_clk_dst(i_clk_link),
        .i_rst_dst(rst_link),
        .o_pulse(ack_evt)
    );

    // link domain state
    sirp_pkg::sirp_state_type st_r, st_nxt;
    logic [1:0] pin_d_r;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [7:0] ptr_r, ptr_nxt;
    logic rw_r, rw_nxt;
    logic oe_r, oe_nxt;
    logic go_r, go_nxt;
    logic [7:0] rbuf_r, rbuf_nxt;
    sirp_pkg::sirp_req_type req_r, req_nxt;
    logic [7:0] rd_r;
    logic scl_rise, scl_fall, start_c, stop_c;

    // oversampled edges; every bus mode is far slower than the link clock
    assign scl_rise = pin_s[1] & ~pin_d_r[1];
    assign scl_fall = ~pin_s[1] & pin_d_r[1];
    assign start_c = pin_s[1] & pin_d_r[1] & ~pin_s[0] & pin_d_r[0];
    assign stop_c = pin_s[1] & pin_d_r[1] & pin_s[0] & ~pin_d_r[0];
    assign req_go = go_r;

    // bus engine: sample on rising clock, change drive on falling clock
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        ptr_nxt = ptr_r;
        rw_nxt = rw_r;
        oe_nxt = oe_r;
        go_nxt = 1'b0;
        req_nxt = req_r;
        rbuf_nxt = ack_evt ? rd_r : rbuf_r;
        if (start_c) begin
            st_nxt = sirp_pkg::ST_ADDR;
            cnt_nxt = 4'h0;
            oe_nxt = 1'b0;
        end else if (stop_c) begin
            st_nxt = sirp_pkg::ST_IDLE;
            oe_nxt = 1'b0;
        end else begin
            unique case (st_r)
                sirp_pkg::ST_IDLE: begin
                    oe_nxt = 1'b0;
                end
                sirp_pkg::ST_ADDR, sirp_pkg::ST_REG, sirp_pkg::ST_WDATA: begin
                    if (scl_rise && cnt_r != `SIRP_BITS) begin
                        sh_nxt = {sh_r[6:0], pin_s[0]};
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (scl_fall && cnt_r == `SIRP_BITS) begin
                        oe_nxt = 1'b1;
                        if (st_r == sirp_pkg::ST_REG) begin
                            ptr_nxt = sh_r;
                            st_nxt = sirp_pkg::ST_ACK_REG;
                        end else if (st_r == sirp_pkg::ST_WDATA) begin
                            req_nxt = '{wr: 1'b1, addr: ptr_r, wdata: sh_r};
                            go_nxt = 1'b1;
                            st_nxt = sirp_pkg::ST_ACK_DATA;
                        end else if (sh_r[7:1] == `SIRP_TGT_ADDR) begin
                            rw_nxt = sh_r[0];
                            st_nxt = sirp_pkg::ST_ACK_ADDR;
                            if (sh_r[0]) begin
                                req_nxt = '{wr: 1'b0, addr: ptr_r, wdata: 8'h00};
                                go_nxt = 1'b1;
                            end
                        end else begin
                            oe_nxt = 1'b0;
                            st_nxt = sirp_pkg::ST_IDLE;
                        end
                    end
                end
                sirp_pkg::ST_ACK_ADDR: begin
                    if (scl_fall) begin
                        cnt_nxt = 4'h0;
                        if (rw_r) begin
                            sh_nxt = {rbuf_r[6:0], 1'b0};
                            oe_nxt = ~rbuf_r[7];
                            cnt_nxt = 4'h1;
                            st_nxt = sirp_pkg::ST_RDATA;
                        end else begin
                            oe_nxt = 1'b0;
                            st_nxt = sirp_pkg::ST_REG;
                        end
                    end
                end
                sirp_pkg::ST_ACK_REG: begin
                    if (scl_fall) begin
                        oe_nxt = 1'b0;
                        cnt_nxt = 4'h0;
                        st_nxt = sirp_pkg::ST_WDATA;
                    end
                end
                sirp_pkg::ST_ACK_DATA: begin
                    if (scl_fall) begin
                        oe_nxt = 1'b0; // further bytes are left unanswered
                        st_nxt = sirp_pkg::ST_IDLE;
                    end
                end
                sirp_pkg::ST_RDATA: begin
                    if (scl_fall) begin
                        if (cnt_r == `SIRP_BITS) begin
                            oe_nxt = 1'b0;
                            st_nxt = sirp_pkg::ST_HOST_ACK;
                        end else begin
                            oe_nxt = ~sh_r[7];
                            sh_nxt = {sh_r[6:0], 1'b0};
                            cnt_nxt = cnt_r + 4'h1;
                        end
                    end
                end
                sirp_pkg::ST_HOST_ACK: begin
                    if (scl_rise) begin
                        st_nxt = sirp_pkg::ST_IDLE; // one byte per read
                    end
                end
                default: begin
                    st_nxt = sirp_pkg::ST_IDLE;
                    oe_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_link) begin
        pin_d_r <= pin_s;
        if (rst_link) begin
            st_r <= sirp_pkg::ST_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            ptr_r <= `SIRP_REG_BASE;
            rw_r <= 1'b0;
            oe_r <= 1'b0;
            go_r <= 1'b0;
            rbuf_r <= 8'h00;
            req_r <= '0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            ptr_r <= ptr_nxt;
            rw_r <= rw_nxt;
            oe_r <= oe_nxt;
            go_r <= go_nxt;
            rbuf_r <= rbuf_nxt;
            req_r <= req_nxt;
        end
    end

    // open drain: only ever pulls low
    assign o_sda_out = 1'b0;
    assign o_sda_oe = oe_r;

    // system domain: command register, flags and register file
    logic [7:0] cmd_r, cmd_nxt;
    logic [7:0] mem_r [1:NREG-1];
    logic [7:0] mem_nxt [1:NREG-1];
    logic amb_st_r, amb_st_nxt, bio_st_r, bio_st_nxt;
    logic int_r, int_nxt;
    logic ack_r, ack_nxt;
    logic [7:0] rd_nxt;
    logic [4:0] idx;
    logic [7:0] wd;
    logic clr_amb, clr_bio, od_ok;

    assign idx = reg_idx(req_r.addr);
    assign wd = req_r.wdata;
    // request word is held by the link side until the answer returns
    assign clr_amb = req_evt && !req_r.wr && in_map(req_r.addr)
                     && (idx == `SIRP_IDX_AMB_HI || idx == `SIRP_IDX_AMB_LO);
    assign clr_bio = req_evt && !req_r.wr && in_map(req_r.addr)
                     && (idx == `SIRP_IDX_BIO_HI || idx == `SIRP_IDX_BIO_LO);
    assign od_ok = !wd[`SIRP_CMD_SELF];
    assign ack_go = ack_r;

    always_comb begin
        cmd_nxt = cmd_r;
        mem_nxt = mem_r;
        amb_st_nxt = 1'b0;
        bio_st_nxt = 1'b0;
        ack_nxt = 1'b0;
        rd_nxt = rd_r;
        if (req_evt) begin
            ack_nxt = 1'b1;
            rd_nxt = 8'h00; // outside the map reads zero
            if (req_r.wr && in_map(req_r.addr)) begin
                if (idx == `SIRP_IDX_CMD) begin
                    cmd_nxt[2:0] = wd[2:0];
                    // on-demand bits only act with self-timed off
                    cmd_nxt[`SIRP_CMD_AMB_OD] = wd[`SIRP_CMD_AMB_OD] & od_ok;
                    cmd_nxt[`SIRP_CMD_BIO_OD] = wd[`SIRP_CMD_BIO_OD] & od_ok;
                    amb_st_nxt = wd[`SIRP_CMD_AMB_OD] & od_ok;
                    bio_st_nxt = wd[`SIRP_CMD_BIO_OD] & od_ok;
                end else if (idx < `SIRP_IDX_AMB_HI || idx > `SIRP_IDX_BIO_LO) begin
                    mem_nxt[idx] = wd; // result registers ignore writes
                end
            end else if (in_map(req_r.addr)) begin
                unique case (idx)
                    `SIRP_IDX_CMD: rd_nxt = cmd_r;
                    `SIRP_IDX_AMB_HI: rd_nxt = i_ambient_result[15:8];
                    `SIRP_IDX_AMB_LO: rd_nxt = i_ambient_result[7:0];
                    `SIRP_IDX_BIO_HI: rd_nxt = i_bio_result[15:8];
                    `SIRP_IDX_BIO_LO: rd_nxt = i_bio_result[7:0];
                    default: rd_nxt = mem_r[idx];
                endcase
            end
        end
        // on-demand bits drop when their conversion ends
        if (i_ambient_done) begin
            cmd_nxt[`SIRP_CMD_AMB_OD] = 1'b0;
        end
        if (i_bio_done) begin
            cmd_nxt[`SIRP_CMD_BIO_OD] = 1'b0;
        end
        // set beats clear when both land in one cycle
        cmd_nxt[`SIRP_CMD_AMB_RDY] = (cmd_r[`SIRP_CMD_AMB_RDY] & ~clr_amb)
                                     | i_ambient_done;
        cmd_nxt[`SIRP_CMD_BIO_RDY] = (cmd_r[`SIRP_CMD_BIO_RDY] & ~clr_bio)
                                     | i_bio_done;
        cmd_nxt[`SIRP_CMD_LOCK] = 1'b1;
        int_nxt = cmd_nxt[`SIRP_CMD_AMB_RDY] | cmd_nxt[`SIRP_CMD_BIO_RDY];
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            cmd_r <= `SIRP_CMD_RST;
            for (int i = 1; i < NREG; i++) begin
                mem_r[i] <= `SIRP_MEM_RST;
            end
            amb_st_r <= 1'b0;
            bio_st_r <= 1'b0;
            int_r <= 1'b0;
            ack_r <= 1'b0;
            rd_r <= 8'h00;
        end else begin
            cmd_r <= cmd_nxt;
            mem_r <= mem_nxt;
            amb_st_r <= amb_st_nxt;
            bio_st_r <= bio_st_nxt;
            int_r <= int_nxt;
            ack_r <= ack_nxt;
            rd_r <= rd_nxt;
        end
    end

    // interrupt pin pulled low while any result is waiting
    assign o_int_out = 1'b0;
    assign o_int_oe = int_r;
    assign o_ambient_start = amb_st_r;
    assign o_bio_start = bio_st_r;
    assign o_ambient_periodic = cmd_r[`SIRP_CMD_AMB_EN];
    assign o_bio_periodic = cmd_r[`SIRP_CMD_BIO_EN];
    assign o_self_timed = cmd_r[`SIRP_CMD_SELF];

    // checks, system domain
    sequence s_cmd_wr_both;
        req_evt && req_r.wr && req_r.addr == `SIRP_REG_BASE
        && wd[`SIRP_CMD_AMB_OD] && wd[`SIRP_CMD_BIO_OD] && od_ok;
    endsequence

    sequence s_amb_read;
        clr_amb && !i_ambient_done;
    endsequence

    chk_dual_start: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        s_cmd_wr_both |=> o_ambient_start && o_bio_start ##1 !o_ambient_start)
        else $error("both on-demand bits did not start both channels");

    chk_od_blocked: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        req_evt && req_r.wr && idx == `SIRP_IDX_CMD && !od_ok
        |=> !o_ambient_start && !o_bio_start)
        else $error("on-demand start while self-timed set");

    chk_lock_one: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        req_evt && !req_r.wr && req_r.addr == `SIRP_REG_BASE |=> rd_r[7])
        else $error("lock bit read back as zero");

    chk_amb_set: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        i_ambient_done |=> cmd_r[`SIRP_CMD_AMB_RDY] && o_int_oe)
        else $error("ambient ready not set by result");

    chk_amb_clear: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        s_amb_read |=> !cmd_r[`SIRP_CMD_AMB_RDY])
        else $error("ambient ready not cleared by result read");

    chk_bio_clear: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        clr_bio && !i_bio_done |=> !cmd_r[`SIRP_CMD_BIO_RDY])
        else $error("bio ready not cleared by result read");

    chk_unmapped_zero: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        req_evt && !req_r.wr && !in_map(req_r.addr) |=> rd_r == 8'h00 && ack_r)
        else $error("unmapped read returned data");

    // checks, link domain
    chk_foreign_addr: assert property (
        @(posedge i_clk_link) disable iff (rst_link)
        st_r == sirp_pkg::ST_ACK_ADDR |-> sh_r[7:1] == `SIRP_TGT_ADDR)
        else $error("acknowledged a foreign address");

    chk_ack_drive: assert property (
        @(posedge i_clk_link) disable iff (rst_link)
        $rose(st_r == sirp_pkg::ST_ACK_REG) |-> o_sda_oe && !o_sda_out)
        else $error("register byte not acknowledged");

    chk_read_dir: assert property (
        @(posedge i_clk_link) disable iff (rst_link)
        st_r == sirp_pkg::ST_RDATA |-> rw_r && req_r.addr == ptr_r)
        else $error("read phase without read direction");
endmodule

`default_nettype wire

// >>> hw/sirp_defs.svh
/*
 * constants of the sensor two-wire register port: target address,
 * register map, command bit positions and reset values.
 * assumes it is included by bare name before any use.
 */
`ifndef SIRP_DEFS_SVH
`define SIRP_DEFS_SVH

`define SIRP_TGT_ADDR 7'h13
`define SIRP_REG_BASE 8'h80
`define SIRP_REG_LAST 8'h90
`define SIRP_REG_COUNT 17
`define SIRP_IDX_CMD 5'h00
`define SIRP_IDX_AMB_HI 5'h05
`define SIRP_IDX_AMB_LO 5'h06
`define SIRP_IDX_BIO_HI 5'h07
`define SIRP_IDX_BIO_LO 5'h08
`define SIRP_CMD_LOCK 7
`define SIRP_CMD_AMB_RDY 6
`define SIRP_CMD_BIO_RDY 5
`define SIRP_CMD_AMB_OD 4
`define SIRP_CMD_BIO_OD 3
`define SIRP_CMD_AMB_EN 2
`define SIRP_CMD_BIO_EN 1
`define SIRP_CMD_SELF 0
`define SIRP_CMD_RST 8'h80
`define SIRP_MEM_RST 8'h00
`define SIRP_BITS 4'h8

`endif

// >>> hw/sirp_pkg.sv
/*
 * types of the sensor two-wire register port.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package sirp_pkg;

    // one register access handed from the link side to the system side
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sirp_req_type;

    // link engine states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ACK_ADDR = 4'h2,
        ST_REG = 4'h3,
        ST_ACK_REG = 4'h4,
        ST_WDATA = 4'h5,
        ST_ACK_DATA = 4'h6,
        ST_RDATA = 4'h7,
        ST_HOST_ACK = 4'h8
    } sirp_state_type;

endpackage

// >>> hw/sirp_sync.sv
/*
 * two flip-flop level synchroniser, W bits wide.
 * assumes each bit is a level that may change at any time.
 */
`timescale 1ns/1ps
`default_nettype none

module sirp_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    // first stage is read by the second stage only
    always_ff @(posedge i_clk) begin
        meta_r <= i_d;
        q_r <= meta_r;
    end

    assign o_q = q_r;
endmodule

`default_nettype wire

// >>> hw/sirp_pulse_xfer.sv
/*
 * single-cycle event crossing by toggle and synchroniser.
 * assumes events in the source domain are spaced wider than
 * three destination clocks, which the handshake guarantees.
 */
`timescale 1ns/1ps
`default_nettype none

module sirp_pulse_xfer (
    input wire logic i_clk_src,
    input wire logic i_rst_src,
    input wire logic i_pulse,
    input wire logic i_clk_dst,
    input wire logic i_rst_dst,
    output logic o_pulse
);
    logic tgl_r;
    logic tgl_nxt;
    logic [2:0] dst_r;
    logic [2:0] dst_nxt;

    // source toggles once per event
    always_comb begin
        tgl_nxt = tgl_r ^ i_pulse;
    end

    always_ff @(posedge i_clk_src) begin
        if (i_rst_src) begin
            tgl_r <= 1'b0;
        end else begin
            tgl_r <= tgl_nxt;
        end
    end

    // destination: two stages, then a delayed copy for the edge
    always_comb begin
        dst_nxt = {dst_r[1:0], tgl_r};
    end

    always_ff @(posedge i_clk_dst) begin
        if (i_rst_dst) begin
            dst_r <= 3'h0;
        end else begin
            dst_r <= dst_nxt;
        end
    end

    assign o_pulse = dst_r[2] ^ dst_r[1];
endmodule

`default_nettype wire

// >>> bench/sirp_host_model.sv
/*
 * bus host model for the sensor port: makes the bus clock, drives data.
 * assumes a pull-up on data and the device pulling low via i_dev_low.
 */
`timescale 1ns/1ps
`default_nettype none

module sirp_host_model (
    input wire logic i_clk,
    input wire logic i_dev_low,
    output var logic o_scl,
    output logic o_sda
);
    logic low_r;

    // wire level: high by pull-up unless a party pulls low
    assign o_sda = ~(low_r | i_dev_low);

    // idle bus, nobody pulls
    initial begin
        o_scl = 1'b1;
        low_r = 1'b0;
    end

    // quarter bit; long low phase so read data can cross domains
    task automatic q();
        repeat (15) @(posedge i_clk);
    endtask

    // start: data falls while clock high
    task automatic start();
        low_r <= 1'b0;
        q();
        o_scl <= 1'b1;
        q();
        low_r <= 1'b1;
        q();
        o_scl <= 1'b0;
    endtask

    // stop: data rises while clock high
    task automatic stop();
        low_r <= 1'b1;
        q();
        o_scl <= 1'b1;
        q();
        low_r <= 1'b0;
        q();
    endtask

    // one bit out, wire sampled mid clock-high
    task automatic bit_io(input logic b, output logic s);
        low_r <= ~b;
        q();
        q();
        o_scl <= 1'b1;
        q();
        s = o_sda;
        q();
        o_scl <= 1'b0;
    endtask

    // eight bits msb first, then the acknowledge slot
    task automatic byte_io(input logic [7:0] d, input logic ack_in, output logic [7:0] r,
                           output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r[i]);
        end
        bit_io(ack_in, s);
        ack = ~s;
    endtask

    // register write: address, register, one data byte
    task automatic wr(input logic [6:0] a, input logic [7:0] ra, input logic [7:0] d,
                      output logic [2:0] acks);
        logic [7:0] r;
        start();
        byte_io({a, 1'b0}, 1'b1, r, acks[2]);
        byte_io(ra, 1'b1, r, acks[1]);
        byte_io(d, 1'b1, r, acks[0]);
        stop();
    endtask

    // register read: address, one byte back, host acknowledges
    task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic ack);
        logic a2;
        start();
        byte_io({a, 1'b1}, 1'b1, d, ack);
        byte_io(8'hff, 1'b0, d, a2);
        stop();
    endtask
endmodule

`default_nettype wire

// >>> bench/tb.sv
/*
 * self-checking bench of the sensor two-wire register port.
 * assumes the host model on the bus and a stub measurement engine here.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic i_clk_sys, i_clk_link, i_rst, scl, sda, sda_oe, sda_out, int_oe, int_out;
    logic amb_done, bio_done, amb_st, bio_st, amb_per, bio_per, self_t;
    int n_fail, checks, n_amb, n_bio;

    // system clock
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    // link clock, offset so its edges never meet the system clock's
    initial begin
        i_clk_link = 1'b0;
        #3;
        forever #7.5 i_clk_link = ~i_clk_link;
    end

    sirp_host_model host (.i_clk(i_clk_sys), .i_dev_low(sda_oe), .o_scl(scl), .o_sda(sda));

    sirp_i2c_port uut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_clk_link(i_clk_link),
        .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
        .o_int_out(int_out), .o_int_oe(int_oe), .i_ambient_done(amb_done),
        .i_bio_done(bio_done), .i_ambient_result(16'h1234), .i_bio_result(16'h5678),
        .o_ambient_start(amb_st), .o_bio_start(bio_st), .o_ambient_periodic(amb_per),
        .o_bio_periodic(bio_per), .o_self_timed(self_t));

    // count start pulses seen
    always @(posedge i_clk_sys) begin
        if (amb_st === 1'b1) n_amb++;
        if (bio_st === 1'b1) n_bio++;
    end

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // write to our own address, all three bytes must be acknowledged
    task automatic wr_ok(input logic [7:0] ra, input logic [7:0] d);
        logic [2:0] a;
        host.wr(7'h13, ra, d, a);
        chk("write acks", 8'h07, {5'h00, a});
    endtask

    // read from our own address and compare the byte
    task automatic rd_chk(input string nm, input logic [7:0] e);
        logic [7:0] d;
        logic ack;
        host.rd(7'h13, d, ack);
        chk("read ack", 8'h01, {7'h00, ack});
        chk(nm, e, d);
    endtask

    // one-cycle result-stored pulses from the stub engine
    task automatic done_pulse(input logic amb, input logic bio);
        @(posedge i_clk_sys);
        amb_done <= amb;
        bio_done <= bio;
        @(posedge i_clk_sys);
        amb_done <= 1'b0;
        bio_done <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
    endtask

    task automatic t_reset();
        chk("idle outputs", 8'h00, {sda_oe, int_oe, amb_st, bio_st, amb_per, bio_per, self_t,
            sda_out | int_out});
        rd_chk("command at reset", 8'h80);
        $display("test reset done");
    endtask

    task automatic t_regs();
        logic [7:0] list [4] = '{8'h81, 8'h84, 8'h89, 8'h90};
        foreach (list[i]) begin
            wr_ok(list[i], list[i] ^ 8'h5a);
            rd_chk("plain register", list[i] ^ 8'h5a);
        end
        wr_ok(8'h91, 8'h33);
        rd_chk("unmapped register", 8'h00);
        $display("test regs done");
    endtask

    task automatic t_foreign();
        logic [2:0] a;
        logic [7:0] d;
        logic ack;
        host.wr(7'h12, 8'h80, 8'h1f, a);
        chk("foreign write acks", 8'h00, {5'h00, a});
        host.rd(7'h53, d, ack);
        // released wire reads all ones, and no acknowledge on the address
        chk("foreign read", 8'hfe, {d[7:1], ack});
        rd_chk("pointer kept", 8'h00);
        chk("no starts", 8'h00, {6'h00, amb_st, self_t});
        $display("test foreign done");
    endtask

    task automatic t_cmd();
        n_amb = 0;
        n_bio = 0;
        wr_ok(8'h80, 8'h1e);
        chk("start pulses", 8'h11, {n_amb[3:0], n_bio[3:0]});
        chk("mode levels", 8'h06, {5'h00, amb_per, bio_per, self_t});
        rd_chk("command written", 8'h9e);
        done_pulse(1'b1, 1'b1);
        chk("int after ready", 8'h01, {7'h00, int_oe});
        rd_chk("both ready", 8'he6);
        wr_ok(8'h85, 8'hff);
        rd_chk("ambient high", 8'h12);
        chk("int held by bio", 8'h01, {7'h00, int_oe});
        wr_ok(8'h88, 8'h00);
        rd_chk("bio low", 8'h78);
        chk("int released", 8'h00, {7'h00, int_oe});
        wr_ok(8'h80, 8'h06);
        rd_chk("flags cleared", 8'h86);
        $display("test command done");
    endtask

    task automatic t_self();
        n_amb = 0;
        n_bio = 0;
        wr_ok(8'h80, 8'h19);
        chk("starts blocked", 8'h00, {n_amb[3:0], n_bio[3:0]});
        chk("self level", 8'h01, {7'h00, self_t});
        wr_ok(8'h80, 8'h00);
        chk("self off", 8'h00, {7'h00, self_t});
        $display("test self done");
    endtask

    // watchdog: some 25 transfers of under 1800 cycles each, with margin
    initial begin
        repeat (60000) @(posedge i_clk_sys);
        n_fail++;
        $display("watchdog expired");
        report_and_stop();
    end

    // main sequence
    initial begin
        n_fail = 0;
        checks = 0;
        i_rst = 1'b1;
        amb_done = 1'b0;
        bio_done = 1'b0;
        repeat (6) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        repeat (10) @(posedge i_clk_sys);
        t_reset();
        t_regs();
        t_foreign();
        t_cmd();
        t_self();
        report_and_stop();
    end
endmodule

`default_nettype wire
